// ===== inc/txk_pkg.sv
// Shared constants and types for the transmit keying and battery block.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
package txk_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BIT_RATE_MAX_BPS = 20_000;
  // Fastest bit period, in pclk cycles
  localparam logic [15:0] MIN_BIT_CYCLES = 16'(CLK_HZ / BIT_RATE_MAX_BPS);
  localparam logic [15:0] RATE_RESET = MIN_BIT_CYCLES;

  // Register byte addresses
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_RATE = 32'h0000_0004;
  localparam logic [31:0] ADDR_POWER = 32'h0000_0008;
  localparam logic [31:0] ADDR_DATA = 32'h0000_000C;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
  localparam logic [31:0] ADDR_BATT = 32'h0000_0014;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FSK_BIT = 1;
  localparam int ST_CODE_LSB = 0;
  localparam int ST_EMPTY_BIT = 8;
  localparam int ST_FULL_BIT = 9;
  localparam int ST_BUSY_BIT = 10;
  localparam int BATT_LIVE_LSB = 8;

  // Power steps: 19.5 dB span in 0.25 dB steps
  localparam int PWR_W = 7;
  localparam logic [6:0] PWR_STEPS = 7'h4E;
  localparam logic [6:0] PWR_RESET = 7'h00;

  // Battery: fine LSB is 10 mV above 1.2 V; code 0 starts at 1.8 V
  localparam int BATT_FINE_W = 8;
  localparam int BATT_CODE_W = 3;
  localparam int BATT_CODES = 7;
  localparam logic [7:0] BATT_BASE = 8'h3C;
  localparam logic [7:0] BATT_STEP = 8'h0A;

  // Data path
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } txk_tx_t;

  typedef struct packed {
    logic [BATT_FINE_W-1:0] fine;
    logic [BATT_CODE_W-1:0] code;
  } txk_batt_t;

  typedef struct packed {
    logic pa_en;
    logic vco_shift;
    logic tx_bit;
  } txk_rf_t;
endpackage

// ===== core/txk_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; in_ready low means the writer must hold its word.
`timescale 1ns/100ps
module txk_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Space available
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes word
  output logic [W-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage has no reset; contents are only read when counted valid
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ===== core/txk_top.sv
// Transmit keying, output power step and loaded-battery capture.
// Assumes an APB master on pclk and an async battery reading bus.
//
// What this block does
// - The battery code is three bits, 000 for 1.8 V up by 0.1 V to 111.
// - The battery code is readable as a field of the status register.
// - The battery level is captured as the first bit of a frame goes out after idle, not for back-to-back frames.
// - The captured level is held for the next message, not the current.
// - An eight-bit finer battery reading is also readable.
// - In on-off keying the amplifier enable follows the sent bit.
// - In frequency shift keying the sent bit steers the oscillator.
// - The bit rate is programmable and reaches 20 kbps in both modes.
// - Output power is a step code covering 19.5 dB in 0.25 dB steps.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module txk_top
  import txk_pkg::*;
(
  input wire logic pclk, // 50 MHz system clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [7:0] batt_adc, // Loaded supply reading, async
  output txk_rf_t rf, // Amplifier and oscillator keying
  output logic [PWR_W-1:0] power_code // Amplifier power step
);
  // Control and held state
  logic ctrl_en, next_ctrl_en;
  logic ctrl_fsk, next_ctrl_fsk;
  logic [15:0] rate, next_rate;
  logic [PWR_W-1:0] next_power_code;
  txk_batt_t batt_held, next_batt_held;

  // Battery reading synchroniser
  logic [7:0] batt_s1, batt_s2, batt_s3;
  logic [7:0] batt_now, next_batt_now;
  logic [BATT_CODES:1] above;
  logic [BATT_CODE_W-1:0] code_now;

  // Transmitter
  txk_tx_t state, next_state;
  logic [15:0] bit_cnt, next_bit_cnt;
  logic [DATA_W-1:0] shreg, next_shreg;
  logic [2:0] nbits, next_nbits;
  logic [15:0] period;
  txk_rf_t next_rf;
  logic capture;

  // APB
  logic acc, commit, stall, hit;
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata, rd_word;

  // FIFO ports
  logic f_in_valid, f_in_ready;
  logic f_out_valid, f_out_ready;
  logic [DATA_W-1:0] f_out_data;

  // Words from software queue here so firmware can run ahead of the bits
  txk_fifo #(
    .W(DATA_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(pwdata[DATA_W-1:0]),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Battery code thresholds, one comparator per code step
  for (genvar k = 1; k <= BATT_CODES; k++) begin : g_thr
    assign above[k] = (batt_now >= 8'(BATT_BASE + k * BATT_STEP));
  end

  // Thermometer count saturates at both ends by construction
  always_comb begin
    code_now = '0;
    for (int k = 1; k <= BATT_CODES; k++) begin
      code_now = code_now + BATT_CODE_W'(above[k]);
    end
  end

  // Sync: accept a new reading only once stages two and three agree
  always_comb begin
    next_batt_now = (batt_s2 == batt_s3) ? batt_s3 : batt_now;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      batt_s1 <= '0;
      batt_s2 <= '0;
      batt_s3 <= '0;
      batt_now <= '0;
    end else begin
      batt_s1 <= batt_adc;
      batt_s2 <= batt_s1;
      batt_s3 <= batt_s2;
      batt_now <= next_batt_now;
    end
  end

  // Register file and APB slave
  always_comb begin
    acc = psel & penable & ~pready;
    commit = psel & penable & pready;
    hit = (paddr == ADDR_CTRL) || (paddr == ADDR_RATE) ||
          (paddr == ADDR_POWER) || (paddr == ADDR_DATA) ||
          (paddr == ADDR_STATUS) || (paddr == ADDR_BATT);
    // A data write waits in the access phase while the FIFO is full
    stall = acc & pwrite & (paddr == ADDR_DATA) & ~f_in_ready;
    next_pready = acc & ~stall;
    next_pslverr = acc & ~stall & ~hit;
    f_in_valid = commit & pwrite & (paddr == ADDR_DATA);

    rd_word = '0;
    if (paddr == ADDR_CTRL) begin
      rd_word[CTRL_EN_BIT] = ctrl_en;
      rd_word[CTRL_FSK_BIT] = ctrl_fsk;
    end else if (paddr == ADDR_RATE) begin
      rd_word[15:0] = rate;
    end else if (paddr == ADDR_POWER) begin
      rd_word[PWR_W-1:0] = power_code;
    end else if (paddr == ADDR_STATUS) begin
      rd_word[ST_CODE_LSB +: BATT_CODE_W] = batt_held.code;
      rd_word[ST_EMPTY_BIT] = ~f_out_valid;
      rd_word[ST_FULL_BIT] = ~f_in_ready;
      rd_word[ST_BUSY_BIT] = (state == TX_SEND);
    end else if (paddr == ADDR_BATT) begin
      rd_word[BATT_FINE_W-1:0] = batt_held.fine;
      rd_word[BATT_LIVE_LSB +: BATT_FINE_W] = batt_now;
    end
    next_prdata = (acc & ~pwrite & ~stall) ? rd_word : prdata;

    next_ctrl_en = ctrl_en;
    next_ctrl_fsk = ctrl_fsk;
    next_rate = rate;
    next_power_code = power_code;
    if (commit & pwrite) begin
      if (paddr == ADDR_CTRL) begin
        next_ctrl_en = pwdata[CTRL_EN_BIT];
        next_ctrl_fsk = pwdata[CTRL_FSK_BIT];
      end else if (paddr == ADDR_RATE) begin
        next_rate = pwdata[15:0];
      end else if (paddr == ADDR_POWER) begin
        // Codes past the top step clamp to full power
        next_power_code = (pwdata[PWR_W-1:0] > PWR_STEPS) ?
                          PWR_STEPS : pwdata[PWR_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      ctrl_en <= 1'b0;
      ctrl_fsk <= 1'b0;
      rate <= RATE_RESET;
      power_code <= PWR_RESET;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      ctrl_en <= next_ctrl_en;
      ctrl_fsk <= next_ctrl_fsk;
      rate <= next_rate;
      power_code <= next_power_code;
    end
  end

  // Bit timing; periods shorter than the 20 kbps limit are raised to it
  always_comb begin
    period = (rate < MIN_BIT_CYCLES) ? MIN_BIT_CYCLES : rate;
  end

  // Transmit sequencer: bytes go out MSB first, frames run while data waits
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_nbits = nbits;
    f_out_ready = 1'b0;
    capture = 1'b0;
    case (state)
      TX_IDLE: begin
        if (ctrl_en && f_out_valid) begin
          f_out_ready = 1'b1;
          next_shreg = f_out_data;
          next_nbits = BIT_LAST;
          next_bit_cnt = period - 16'h0001;
          next_state = TX_SEND;
          capture = 1'b1;
        end
      end
      TX_SEND: begin
        if (bit_cnt != 16'h0000) begin
          next_bit_cnt = bit_cnt - 16'h0001;
        end else if (nbits != 3'h0) begin
          next_shreg = {shreg[DATA_W-2:0], 1'b0};
          next_nbits = nbits - 3'h1;
          next_bit_cnt = period - 16'h0001;
        end else if (ctrl_en && f_out_valid) begin
          f_out_ready = 1'b1;
          next_shreg = f_out_data;
          next_nbits = BIT_LAST;
          next_bit_cnt = period - 16'h0001;
        end else begin
          next_state = TX_IDLE;
        end
      end
      default: begin
        next_state = TX_IDLE;
      end
    endcase

    next_rf.tx_bit = (next_state == TX_SEND) & next_shreg[DATA_W-1];
    next_rf.pa_en = (next_state == TX_SEND) &
                    (ctrl_fsk | next_rf.tx_bit);
    next_rf.vco_shift = (next_state == TX_SEND) & ctrl_fsk &
                        next_rf.tx_bit;

    // Held until a frame starts from idle, for the next message's payload
    next_batt_held = batt_held;
    if (capture) begin
      next_batt_held.code = code_now;
      next_batt_held.fine = batt_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= TX_IDLE;
      bit_cnt <= '0;
      shreg <= '0;
      nbits <= '0;
      rf <= '0;
      batt_held <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      nbits <= next_nbits;
      rf <= next_rf;
      batt_held <= next_batt_held;
    end
  end

  AST_CODE_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (batt_now < BATT_BASE) |-> (code_now == 3'h0))
    else $error("Battery code not zero below 1.8 V");

  AST_CODE_SAT: assert property (@(posedge pclk) disable iff (!presetn)
    (batt_now >= 8'h82) |-> (code_now == 3'h7))
    else $error("Battery code not saturated at top");

  AST_STATUS_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && !stall && paddr == ADDR_STATUS) |=>
    (prdata[2:0] == $past(batt_held.code)))
    else $error("Status read lost the battery code");

  AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
    (state == TX_IDLE && next_state == TX_SEND) |=>
    (batt_held.code == $past(code_now)) &&
    (batt_held.fine == $past(batt_now)))
    else $error("Battery not captured at first bit");

  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !capture |=> $stable(batt_held))
    else $error("Held battery value changed outside frame start");

  AST_FINE: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !pwrite && !stall && paddr == ADDR_BATT) |=>
    (prdata[7:0] == $past(batt_held.fine)))
    else $error("Fine battery read mismatch");

  AST_OOK: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(next_state) == TX_SEND && !$past(ctrl_fsk)) |->
    (rf.pa_en == rf.tx_bit) && !rf.vco_shift)
    else $error("Amplifier enable does not follow bit");

  AST_FSK: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(next_state) == TX_SEND && $past(ctrl_fsk)) |->
    rf.pa_en && (rf.vco_shift == rf.tx_bit))
    else $error("Oscillator shift does not follow bit");

  AST_BIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (state == TX_SEND && bit_cnt != 16'h0000) |=>
    $stable(rf.tx_bit) && (bit_cnt == $past(bit_cnt) - 16'h0001))
    else $error("Bit changed before its period ended");

  AST_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
    (state == TX_IDLE && next_state == TX_SEND) |=>
    (bit_cnt >= MIN_BIT_CYCLES - 16'h0001))
    else $error("Bit period shorter than 20 kbps limit");

  AST_PWR: assert property (@(posedge pclk) disable iff (!presetn)
    (commit && pwrite && paddr == ADDR_POWER) |=>
    (power_code <= PWR_STEPS))
    else $error("Power code beyond top step");

  AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !stall) |=> pready ##1 !pready)
    else $error("APB answer not a one-cycle pulse");
endmodule

// ===== tb/txk_rf_model.sv
// Amplifier and oscillator model that listens to the keying outputs.
// Assumes frames start with the amplifier switched on (first bit 1 in OOK).
`timescale 1ns/100ps
module txk_rf_model
  import txk_pkg::*;
(
  input wire logic pclk, // System clock
  input wire txk_rf_t rf, // Keying from the block
  input wire logic fsk, // Mode in use
  input wire logic [15:0] bit_cycles, // Cycles per bit
  input wire logic [7:0] level, // Supply reading to present
  output logic [7:0] batt_adc, // Reading into the block
  output logic [7:0] rx_byte, // Last byte heard
  output int rx_count, // Frames heard
  output int rx_bad // Keying faults seen
);
  logic b;

  assign batt_adc = level;

  initial begin
    rx_byte = 8'h00;
    rx_count = 0;
    rx_bad = 0;
    forever begin
      @(posedge pclk iff rf.pa_en === 1'b1);
      for (int k = 7; k >= 0; k--) begin
        b = fsk ? rf.vco_shift : rf.pa_en;
        rx_byte[k] = b;
        repeat (bit_cycles) begin
          // Every cycle of a bit must show the same level
          if ((fsk ? rf.vco_shift : rf.pa_en) !== b || rf.tx_bit !== b ||
              (fsk && rf.pa_en !== 1'b1) ||
              (!fsk && rf.vco_shift !== 1'b0))
            rx_bad++;
          @(posedge pclk);
        end
      end
      // A frame of one byte must leave the carrier quiet at once
      if (rf !== '0)
        rx_bad++;
      rx_count++;
    end
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the keying and battery block.
// Assumes the RF model in tb/ and an APB master reaching the registers.
`timescale 1ns/100ps
module testbench import txk_pkg::*;;
  localparam int NBIT = CLK_HZ / BIT_RATE_MAX_BPS;
  typedef struct {
    logic [7:0] lvl;
    logic fsk;
    logic [7:0] dat;
    logic [15:0] rate;
    logic [6:0] pwr;
    logic [6:0] pwr_exp;
  } txk_row_t;
  txk_row_t rows [3] = '{
    '{8'h32, 1'b0, 8'hA5, 16'h0001, 7'h4E, 7'h4E},
    '{8'h46, 1'b1, 8'hC3, 16'h09C4, 7'h4F, 7'h4E},
    '{8'h81, 1'b0, 8'h96, 16'h0A28, 7'h13, 7'h13}
  };
  logic [31:0] ra [4] = '{ADDR_CTRL, ADDR_RATE, ADDR_POWER, ADDR_STATUS};
  logic [31:0] rv [4] = '{32'h0000_0000, 32'(NBIT), 32'h0000_0000,
                          32'h0000_0100};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fsk, err_v;
  logic [31:0] paddr, pwdata, prdata, rd_v;
  logic [7:0] batt_adc, level, rx_byte;
  logic [6:0] power_code;
  logic [15:0] bit_cycles;
  txk_rf_t rf;
  int rx_count, rx_bad, n0;
  int err_count = 0;
  int num_checks = 0;

  txk_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .batt_adc(batt_adc), .rf(rf), .power_code(power_code));
  txk_rf_model u_rf (.pclk(pclk), .rf(rf), .fsk(fsk),
    .bit_cycles(bit_cycles), .level(level), .batt_adc(batt_adc),
    .rx_byte(rx_byte), .rx_count(rx_count), .rx_bad(rx_bad));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Entered just after an edge; leaves one idle cycle behind it
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50000);
    rd_v = prdata;
    err_v = pslverr;
    if (n >= 50000)
      check("pready", 32'h0000_0000, 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_frame();
    int n;
    n = 0;
    while (rx_count == n0 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    check("frame done", 32'(rx_count), 32'(n0 + 1));
  endtask

  // Reading is 10 mV steps above 1.2 V; 1.8 V to 2.5 V in 0.1 V codes
  function automatic int code_of(input int f);
    if (f < 60)
      return 0;
    return ((f - 60) / 10 > 7) ? 7 : (f - 60) / 10;
  endfunction

  initial begin
    repeat (95000) @(posedge pclk);
    check("watchdog", 32'h0000_0001, 32'h0000_0000);
    print_verdict();
  end

  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 32'h0000_0000;
    pwdata <= 32'h0000_0000;
    level <= 8'h00;
    fsk <= 1'b0;
    bit_cycles <= 16'(NBIT);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      level <= rows[i].lvl;
      fsk <= rows[i].fsk;
      bit_cycles <= (rows[i].rate < NBIT) ? 16'(NBIT) : rows[i].rate;
      apb(1'b1, ADDR_RATE, 32'(rows[i].rate));
      apb(1'b1, ADDR_POWER, 32'(rows[i].pwr));
      apb(1'b0, ADDR_POWER, 32'h0000_0000);
      check("power reg", rd_v, 32'(rows[i].pwr_exp));
      check("power pin", 32'(power_code), 32'(rows[i].pwr_exp));
      apb(1'b1, ADDR_DATA, 32'(rows[i].dat));
      repeat (8) @(posedge pclk);
      n0 = rx_count;
      apb(1'b1, ADDR_CTRL, 32'({rows[i].fsk, 1'b1}));
      // Supply moves during the first bit; the held value must not
      repeat (40) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      check("busy", rd_v, 32'(code_of(rows[i].lvl)) |
            (32'h0000_0001 << ST_EMPTY_BIT) |
            (32'h0000_0001 << ST_BUSY_BIT));
      level <= rows[i].lvl + 8'h03;
      wait_frame();
      apb(1'b1, ADDR_CTRL, 32'h0000_0000);
      check("byte", 32'(rx_byte), 32'(rows[i].dat));
      check("keying", rx_bad, 0);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      check("status", rd_v, 32'(code_of(rows[i].lvl)) |
            (32'h0000_0001 << ST_EMPTY_BIT));
      apb(1'b0, ADDR_BATT, 32'h0000_0000);
      check("batt", rd_v,
            {16'h0000, rows[i].lvl + 8'h03, rows[i].lvl});
    end
    // Full queue, enable dropped mid byte, so only one byte sent
    level <= 8'hC8;
    fsk <= 1'b0;
    bit_cycles <= 16'(NBIT);
    apb(1'b1, ADDR_RATE, 32'(NBIT));
    for (int i = 0; i < FIFO_DEPTH; i++)
      apb(1'b1, ADDR_DATA, 32'h0000_0081 + 32'(i));
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    check("full", 32'(rd_v[ST_FULL_BIT]), 32'h0000_0001);
    n0 = rx_count;
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_DATA, 32'h0000_0055);
    wait_frame();
    check("byte", 32'(rx_byte), 32'h0000_0081);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    check("status", rd_v, 32'(code_of(200)) |
          (32'h0000_0001 << ST_FULL_BIT));
    repeat (3000) @(posedge pclk);
    check("frames", 32'(rx_count), 32'(n0 + 1));
    check("keying", rx_bad, 0);
    // Unmapped places answer with an error and no data
    apb(1'b0, 32'h0000_0018, 32'h0000_0000);
    check("rd err", 32'(err_v), 32'h0000_0001);
    check("rd data", rd_v, 32'h0000_0000);
    apb(1'b1, 32'h1000_0000, 32'hFFFF_FFFF);
    check("wr err", 32'(err_v), 32'h0000_0001);
    // Second reset clears the queue and the settings
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("power pin", 32'(power_code), 32'h0000_0000);
    check("rf", 32'(rf), 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      check("reset reg", rd_v, rv[i]);
    end
    print_verdict();
  end
endmodule
